// ---- rtl/clb_pkg.sv ----
// shared constants and types for the local bus control ends
package clb_pkg;
	localparam int PCLK_DIV = 2; // system clocks per processor cycle
	localparam int NMI_MIN_CLK = 4; // nmi low and high minimum, system clocks
	localparam int IRQ_LEAD_PCYC = 2; // processor cycles of irq lead
	localparam int IACK_CYCLES = 2; // acknowledge cycles per maskable irq
	localparam logic [7:0] NMI_VECTOR = 8'h02;
	localparam int SYNC_W = 6;
	localparam int SY_HOLD = 0;
	localparam int SY_IRQ = 1;
	localparam int SY_NMI = 2;
	localparam int SY_OPREQ = 3;
	localparam int SY_BUSY = 4;
	localparam int SY_ERR = 5;
	localparam logic [SYNC_W-1:0] SYNC_RST = 6'h30; // busy_n, error_n idle high

	typedef enum logic [2:0] {CYC_MEM_RD, CYC_MEM_WR, CYC_CODE, CYC_IO_RD, CYC_IO_WR, CYC_HALT, CYC_IACK} clb_cyc_t;
	typedef enum logic [2:0] {ST_IDLE, ST_STATUS, ST_CMD, ST_FLOAT, ST_HOLD} clb_bus_st_t;

	// memory/io select level for a cycle type
	function automatic logic clb_mio(input clb_cyc_t t);
		return (t == CYC_MEM_RD) || (t == CYC_MEM_WR) || (t == CYC_CODE) || (t == CYC_HALT);
	endfunction

	// code/acknowledge level for a cycle type
	function automatic logic clb_cod(input clb_cyc_t t);
		return (t == CYC_CODE) || (t == CYC_IO_RD) || (t == CYC_IO_WR);
	endfunction
endpackage

// ---- rtl/clb_if.sv ----
// pins between the processor end and the outside parties
interface clb_if;
	logic m_io_o;
	logic m_io_oe;
	logic code_or_int_ack_o;
	logic code_or_int_ack_oe;
	logic lock_n_o;
	logic lock_n_oe;
	logic cop_operand_ack_n_o;
	logic cop_operand_ack_n_oe;
	logic bus_hold_ack;
	logic status_n;
	logic ready_n;
	logic hold_req;
	logic maskable_irq;
	logic nmi_req;
	logic cop_operand_request;
	logic busy_n;
	logic error_n;
	logic [7:0] vec_data;
	logic m_io;
	logic code_or_int_ack;
	logic lock_n;
	logic cop_operand_ack_n;

	// wire levels: select lines keep their last value, active-low lines float high
	assign m_io = m_io_o;
	assign code_or_int_ack = code_or_int_ack_o;
	assign lock_n = lock_n_oe ? lock_n_o : 1'b1;
	assign cop_operand_ack_n = cop_operand_ack_n_oe ? cop_operand_ack_n_o : 1'b1;

	modport dev (output m_io_o, m_io_oe, code_or_int_ack_o, code_or_int_ack_oe, lock_n_o, lock_n_oe,
		cop_operand_ack_n_o, cop_operand_ack_n_oe, bus_hold_ack, status_n,
		input ready_n, hold_req, maskable_irq, nmi_req, cop_operand_request, busy_n, error_n, vec_data);
	modport host (input m_io, code_or_int_ack, lock_n, cop_operand_ack_n, bus_hold_ack, status_n,
		output ready_n, hold_req, maskable_irq, nmi_req, cop_operand_request, busy_n, error_n, vec_data);
endinterface

// ---- rtl/clb_host.sv ----
// outside parties: bus controller, other master, irq controller, coprocessor
module clb_host import clb_pkg::*; #(
	parameter int WAIT_STATES = 0 // extra command clocks before ready
) (
	input wire logic ref_clk, // system clock
	input wire logic rst, // async reset, high
	clb_if.host bus, // processor pins
	input wire logic mst_req, // other master wants the bus
	output logic mst_grant, // bus handed over
	input wire logic irq_in, // device irq level
	input wire logic [7:0] irq_vec_in, // vector to return
	input wire logic nmi_in, // nmi event pulse
	input wire logic cop_busy, // coprocessor busy
	input wire logic cop_error, // coprocessor error
	input wire logic cop_opreq, // operand transfer wanted, pulse
	output logic cop_op_done // operand transfer acknowledged, pulse
);
	logic hold_q, ready_n_q, irq_q, second_q, nmi_q, opreq_q, busy_n_q, error_n_q;
	logic [7:0] vec_q;
	logic [3:0] nmi_cnt_q;
	logic [7:0] wcnt_q;
	logic wact_q;
	wire iack_seen = !bus.status_n && !bus.m_io && !bus.code_or_int_ack;

	// hold request, raised only when lock is off, kept until master done
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hold_q <= 1'b0;
			mst_grant <= 1'b0;
		end else begin
			if (!hold_q)
				hold_q <= mst_req && bus.lock_n && !bus.bus_hold_ack;
			else if (!mst_req)
				hold_q <= 1'b0;
			mst_grant <= hold_q && bus.bus_hold_ack;
		end
	end

	// ready after the wait states of each cycle, none in hold
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ready_n_q <= 1'b1;
			wact_q <= 1'b0;
			wcnt_q <= 8'h00;
		end else begin
			ready_n_q <= 1'b1;
			if (!bus.status_n && !bus.bus_hold_ack) begin
				wact_q <= 1'b1;
				wcnt_q <= 8'(WAIT_STATES);
			end else if (wact_q) begin
				if (wcnt_q == 8'h00) begin
					ready_n_q <= 1'b0;
					wact_q <= 1'b0;
				end else
					wcnt_q <= wcnt_q - 8'h01;
			end
		end
	end

	// irq held until the first acknowledge, vector on the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
			second_q <= 1'b0;
			vec_q <= 8'h00;
		end else begin
			if (irq_in)
				irq_q <= 1'b1;
			else if (iack_seen && !second_q)
				irq_q <= 1'b0;
			if (iack_seen) begin
				second_q <= !second_q;
				if (second_q)
					vec_q <= irq_vec_in;
			end
		end
	end

	// nmi shaped high then low for the minimum clocks each
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nmi_q <= 1'b0;
			nmi_cnt_q <= 4'h0;
		end else if (nmi_cnt_q != 4'h0) begin
			nmi_cnt_q <= nmi_cnt_q - 4'h1;
			if (nmi_cnt_q == 4'(NMI_MIN_CLK + 1))
				nmi_q <= 1'b0;
		end else if (nmi_in) begin
			nmi_q <= 1'b1;
			nmi_cnt_q <= 4'(2 * NMI_MIN_CLK);
		end
	end

	// coprocessor status and operand request until acknowledged
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_n_q <= 1'b1;
			error_n_q <= 1'b1;
			opreq_q <= 1'b0;
			cop_op_done <= 1'b0;
		end else begin
			busy_n_q <= !cop_busy;
			error_n_q <= !cop_error;
			cop_op_done <= opreq_q && !bus.cop_operand_ack_n;
			if (cop_opreq)
				opreq_q <= 1'b1;
			else if (!bus.cop_operand_ack_n)
				opreq_q <= 1'b0;
		end
	end

	assign bus.hold_req = hold_q;
	assign bus.ready_n = ready_n_q;
	assign bus.maskable_irq = irq_q;
	assign bus.vec_data = vec_q;
	assign bus.nmi_req = nmi_q;
	assign bus.cop_operand_request = opreq_q;
	assign bus.busy_n = busy_n_q;
	assign bus.error_n = error_n_q;
endmodule // clb_host

// ---- rtl/clb_dev.sv ----
// processor end of the local bus control signals
// Functional notes
// - memory/io high for memory and halt
// - code/ack line same timing as select
// - select lines float, keep level, in hold
// - lock blocks other masters, this and next
// - lock for prefix, swap, ack, descriptors
// - lock active low, floats high in hold
// - cycle waits until ready low
// - ready sampled on clock, ignored in hold
// - float drivers before hold acknowledge
// - hold ack drops when hold drops
// - async hold, acknowledge always driven
// - maskable irq ignored when enable clear
// - two acknowledge cycles fetch 8-bit vector
// - irq held until acknowledge starts
// - irq sampled per processor cycle, two ahead
// - irq level high, synchronised inside
// - nmi vector two, no acknowledge, unmaskable
// - nmi rising edge, four low, four high
// - coprocessor raises operand request
// - operand ack low during transfer, floats high
// - busy stalls wait, still interruptible
// - error gives extension interrupt on wait
// - busy and error active low, async
module clb_dev import clb_pkg::*; (
	input wire logic ref_clk, // system clock
	input wire logic rst, // async reset, high
	clb_if.dev bus, // pins to the outside parties
	input wire logic cyc_req, // core wants a bus cycle, level
	input wire clb_cyc_t cyc_type, // kind of that cycle
	input wire logic cyc_lock, // lock prefix in force
	input wire logic cyc_swap, // memory exchange access
	input wire logic cyc_desc, // descriptor table access
	input wire logic cyc_pe, // operand transfer for coprocessor
	output logic cyc_ack, // core cycle ended, pulse
	input wire logic instr_end, // instruction boundary, pulse
	input wire logic if_flag, // interrupt enable flag
	input wire logic exec_wait, // wait or escape instruction running
	output logic stall, // core must stall on busy
	output logic pe_fault, // extension interrupt wanted
	output logic pe_pending, // coprocessor wants an operand
	output logic irq_take, // interrupt taken, pulse
	output logic [7:0] irq_vector // vector of that interrupt
);
	logic [SYNC_W-1:0] sync1_q, sync2_q;
	clb_bus_st_t st_q;
	clb_cyc_t cur_type_q, nxt_type;
	logic cur_lock_q, cur_pe_q, cur_auto_q, nxt_lock, nxt_pe, nxt_auto;
	logic start_cyc, grant, cyc_end, in_cyc_d, lock_keep_q;
	logic [1:0] iack_left_q;
	logic [1:0] pdiv_q;
	logic [IRQ_LEAD_PCYC-1:0] irq_pipe_q;
	logic nmi_prev_q, nmi_arm_q, nmi_pend_q, nmi_clr, accept;
	logic [2:0] nmi_lo_q, nmi_hi_q;
	logic m_io_q, cod_q, oe_q, lock_n_q, ack_n_q, bus_hold_ack_q, status_n_q;

	wire hold_s = sync2_q[SY_HOLD];
	wire irq_s = sync2_q[SY_IRQ];
	wire nmi_s = sync2_q[SY_NMI];
	wire busy_act = !sync2_q[SY_BUSY];
	wire err_act = !sync2_q[SY_ERR];
	wire pclk_en = (pdiv_q == 2'(PCLK_DIV - 1));

	// two-flop synchronisers for every outside request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
		end else begin
			sync1_q <= {bus.error_n, bus.busy_n, bus.cop_operand_request, bus.nmi_req, bus.maskable_irq, bus.hold_req};
			sync2_q <= sync1_q;
		end
	end

	// pick the next bus owner and cycle
	always_comb begin
		grant = (st_q == ST_IDLE) && hold_s && !lock_keep_q;
		start_cyc = (st_q == ST_IDLE) && !grant && ((iack_left_q != 2'h0) || cyc_req);
		nxt_auto = (iack_left_q != 2'h0);
		nxt_type = nxt_auto ? CYC_IACK : cyc_type;
		nxt_lock = nxt_auto || cyc_lock || cyc_swap || cyc_desc || (cyc_type == CYC_IACK);
		nxt_pe = !nxt_auto && cyc_pe;
		cyc_end = (st_q == ST_CMD) && !bus.ready_n;
		in_cyc_d = start_cyc || (st_q == ST_STATUS) || ((st_q == ST_CMD) && bus.ready_n);
	end

	// bus state machine
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			cur_type_q <= CYC_MEM_RD;
			cur_lock_q <= 1'b0;
			cur_pe_q <= 1'b0;
			cur_auto_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (grant)
						st_q <= ST_FLOAT;
					else if (start_cyc) begin
						st_q <= ST_STATUS;
						cur_type_q <= nxt_type;
						cur_lock_q <= nxt_lock;
						cur_pe_q <= nxt_pe;
						cur_auto_q <= nxt_auto;
					end
				end
				ST_STATUS: st_q <= ST_CMD;
				ST_CMD: begin
					if (cyc_end)
						st_q <= ST_IDLE;
				end
				ST_FLOAT: st_q <= ST_HOLD;
				ST_HOLD: begin
					if (!hold_s)
						st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// pin drivers; drivers float one clock before hold acknowledge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			m_io_q <= 1'b0;
			cod_q <= 1'b0;
			oe_q <= 1'b1;
			bus_hold_ack_q <= 1'b0;
			status_n_q <= 1'b1;
			lock_n_q <= 1'b1;
			ack_n_q <= 1'b1;
			lock_keep_q <= 1'b0;
		end else begin
			if (start_cyc) begin
				m_io_q <= clb_mio(nxt_type);
				cod_q <= clb_cod(nxt_type);
			end
			if (grant)
				oe_q <= 1'b0;
			else if ((st_q == ST_HOLD) && !hold_s)
				oe_q <= 1'b1;
			if (st_q == ST_FLOAT)
				bus_hold_ack_q <= 1'b1;
			else if ((st_q == ST_HOLD) && !hold_s)
				bus_hold_ack_q <= 1'b0;
			status_n_q <= !start_cyc;
			if (cyc_end)
				lock_keep_q <= cur_lock_q;
			lock_n_q <= !((in_cyc_d && (start_cyc ? nxt_lock : cur_lock_q)) || (cyc_end ? cur_lock_q : lock_keep_q));
			ack_n_q <= !(in_cyc_d && (start_cyc ? nxt_pe : cur_pe_q));
		end
	end

	// processor cycle divider and irq sampling pipeline
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pdiv_q <= 2'h0;
			irq_pipe_q <= '0;
		end else begin
			pdiv_q <= pclk_en ? 2'h0 : pdiv_q + 2'h1;
			if (accept)
				irq_pipe_q <= '0;
			else if (pclk_en)
				irq_pipe_q <= {irq_pipe_q[IRQ_LEAD_PCYC-2:0], irq_s && if_flag};
		end
	end

	// nmi: low for four clocks, then a rise held for four
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nmi_prev_q <= 1'b0;
			nmi_arm_q <= 1'b0;
			nmi_pend_q <= 1'b0;
			nmi_lo_q <= 3'h0;
			nmi_hi_q <= 3'h0;
		end else begin
			nmi_prev_q <= nmi_s;
			if (!nmi_s) begin
				nmi_arm_q <= 1'b0;
				if (nmi_lo_q != 3'(NMI_MIN_CLK))
					nmi_lo_q <= nmi_lo_q + 3'h1;
			end else if (!nmi_prev_q) begin
				nmi_arm_q <= (nmi_lo_q == 3'(NMI_MIN_CLK));
				nmi_hi_q <= 3'h1;
				nmi_lo_q <= 3'h0;
			end else if (nmi_arm_q) begin
				nmi_hi_q <= nmi_hi_q + 3'h1;
				if (nmi_hi_q == 3'(NMI_MIN_CLK - 1))
					nmi_arm_q <= 1'b0;
			end
			if (nmi_arm_q && nmi_s && nmi_prev_q && (nmi_hi_q == 3'(NMI_MIN_CLK - 1)))
				nmi_pend_q <= 1'b1;
			else if (nmi_clr)
				nmi_pend_q <= 1'b0;
		end
	end

	// take interrupts at a boundary or while stalled on busy
	always_comb begin
		accept = (instr_end || stall) && (iack_left_q == 2'h0) && !irq_take;
		nmi_clr = accept && nmi_pend_q;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			iack_left_q <= 2'h0;
			irq_take <= 1'b0;
			irq_vector <= 8'h00;
		end else begin
			irq_take <= 1'b0;
			if (nmi_clr) begin
				irq_take <= 1'b1;
				irq_vector <= NMI_VECTOR;
			end else if (accept && (&irq_pipe_q) && if_flag)
				iack_left_q <= 2'(IACK_CYCLES);
			if (cyc_end && cur_auto_q) begin
				iack_left_q <= iack_left_q - 2'h1;
				if (iack_left_q == 2'h1) begin
					irq_take <= 1'b1;
					irq_vector <= bus.vec_data;
				end
			end
		end
	end

	// core handshakes and coprocessor status
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cyc_ack <= 1'b0;
			stall <= 1'b0;
			pe_fault <= 1'b0;
			pe_pending <= 1'b0;
		end else begin
			cyc_ack <= cyc_end && !cur_auto_q;
			stall <= exec_wait && busy_act;
			pe_fault <= exec_wait && !busy_act && err_act;
			pe_pending <= sync2_q[SY_OPREQ];
		end
	end

	assign bus.m_io_o = m_io_q;
	assign bus.m_io_oe = oe_q;
	assign bus.code_or_int_ack_o = cod_q;
	assign bus.code_or_int_ack_oe = oe_q;
	assign bus.lock_n_o = lock_n_q;
	assign bus.lock_n_oe = oe_q;
	assign bus.cop_operand_ack_n_o = ack_n_q;
	assign bus.cop_operand_ack_n_oe = oe_q;
	assign bus.bus_hold_ack = bus_hold_ack_q;
	assign bus.status_n = status_n_q;
endmodule // clb_dev

// ---- bench/clb_props.sv ----
// assertions on the pins between the two local bus control ends
module clb_props (
	input wire logic ref_clk, // system clock
	input wire logic rst, // async reset
	input wire logic m_io_o, // select value
	input wire logic m_io_oe, // shared drive enable
	input wire logic code_or_int_ack_o, // code/ack value
	input wire logic code_or_int_ack_oe, // code/ack enable
	input wire logic lock_n_o, // lock value
	input wire logic lock_n_oe, // lock enable
	input wire logic lock_n, // lock wire
	input wire logic cop_operand_ack_n, // operand ack wire
	input wire logic bus_hold_ack, // hold ack
	input wire logic status_n, // status state
	input wire logic ready_n, // ready
	input wire logic hold_req // hold request
);
	logic open_q; // cycle started, ready not yet seen
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// track cycles still waiting for ready
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) open_q <= 1'b0;
		else if (!status_n) open_q <= 1'b1;
		else if (!ready_n && !bus_hold_ack) open_q <= 1'b0;
	end
	AST_STATUS_ONE: assert property (!status_n |=> status_n) else $error("status longer than one clock");
	AST_NO_STATUS_OPEN: assert property (!status_n |-> !open_q) else $error("new cycle before ready");
	AST_FLOAT_FIRST: assert property ($rose(bus_hold_ack) |-> !m_io_oe && !$past(m_io_oe))
		else $error("hold ack before float");
	AST_SEL_KEEP: assert property (bus_hold_ack && $past(bus_hold_ack) |->
		$stable(m_io_o) && $stable(code_or_int_ack_o)) else $error("select moved in hold");
	AST_LOCK_FLOAT: assert property (bus_hold_ack |->
		lock_n && cop_operand_ack_n && !lock_n_oe && !code_or_int_ack_oe) else $error("lock or ack not floated high");
	AST_BUS_HOLD_ACK_DROP: assert property ($fell(hold_req) |-> ##[1:5] !bus_hold_ack)
		else $error("hold ack kept after hold");
	AST_HOLD_SYNC: assert property ($rose(hold_req) |-> m_io_oe ##1 m_io_oe)
		else $error("hold taken before sync");
	AST_LOCK_NO_HOLD: assert property (!lock_n_o && lock_n_oe |=> m_io_oe)
		else $error("bus given up while locked");
	cover property ($rose(bus_hold_ack));
	cover property (!lock_n && !status_n);
	cover property (!cop_operand_ack_n);
	cover property (!status_n ##1 ready_n ##1 !ready_n);
endmodule // clb_props

// ---- bench/tb_cpu_local_bus_control_signals.sv ----
// self-checking bench joining both ends of the local bus control pins
module tb_cpu_local_bus_control_signals;
	timeunit 1ns;
	timeprecision 1ps;
	import clb_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc_req = 1'b0, cyc_lock = 1'b0, cyc_swap = 1'b0, cyc_desc = 1'b0, cyc_pe = 1'b0;
	clb_cyc_t cyc_type = CYC_MEM_RD;
	logic instr_end = 1'b0, if_flag = 1'b0, exec_wait = 1'b0;
	logic mst_req = 1'b0, irq_in = 1'b0, nmi_in = 1'b0, cop_busy = 1'b0, cop_error = 1'b0, cop_opreq = 1'b0;
	logic [7:0] irq_vec_in = 8'h00;
	logic cyc_ack, stall, pe_fault, pe_pending, irq_take, mst_grant, cop_op_done;
	logic [7:0] irq_vector;
	logic [3:0] st_seen = 4'h0;
	logic [3:0] cyc_q[$];
	logic [7:0] vec_q[$];
	logic [15:0] lfsr_q = 16'h18dc;
	logic prev_lock = 1'b0;
	int mismatches = 0, checks = 0, stat_cnt = 0, done_cnt = 0, s0 = 0, n = 0;
	clb_if bus_if();
	clb_dev clb_dev_i(.ref_clk, .rst, .bus(bus_if.dev), .cyc_req, .cyc_type, .cyc_lock, .cyc_swap, .cyc_desc,
		.cyc_pe, .cyc_ack, .instr_end, .if_flag, .exec_wait, .stall, .pe_fault, .pe_pending, .irq_take, .irq_vector);
	clb_host #(.WAIT_STATES(1)) clb_host_i(.ref_clk, .rst, .bus(bus_if.host), .mst_req, .mst_grant, .irq_in,
		.irq_vec_in, .nmi_in, .cop_busy, .cop_error, .cop_opreq, .cop_op_done);
	clb_props clb_props_i(.ref_clk, .rst, .m_io_o(bus_if.m_io_o), .m_io_oe(bus_if.m_io_oe),
		.code_or_int_ack_o(bus_if.code_or_int_ack_o), .code_or_int_ack_oe(bus_if.code_or_int_ack_oe),
		.lock_n_o(bus_if.lock_n_o), .lock_n_oe(bus_if.lock_n_oe),
		.lock_n(bus_if.lock_n), .cop_operand_ack_n(bus_if.cop_operand_ack_n), .bus_hold_ack(bus_if.bus_hold_ack),
		.status_n(bus_if.status_n), .ready_n(bus_if.ready_n), .hold_req(bus_if.hold_req));
	// clock
	always #20 ref_clk = ~ref_clk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// one core cycle, f = lock, swap, descriptor, operand transfer
	task automatic run_cycle(input clb_cyc_t t, input logic [3:0] f);
		logic lk;
		logic [6:0] mio_tab;
		logic [6:0] cod_tab;
		mio_tab = 7'h27;
		cod_tab = 7'h1c;
		lk = f[3] | f[2] | f[1] | (t == CYC_IACK);
		cyc_q.push_back({mio_tab[t], cod_tab[t], ~(lk | prev_lock), ~f[0]});
		@(negedge ref_clk);
		cyc_type = t;
		{cyc_lock, cyc_swap, cyc_desc, cyc_pe} = f;
		cyc_req = 1'b1;
		for (n = 0; n < 400 && cyc_ack !== 1'b1; n++) @(negedge ref_clk);
		check("cycle end", {7'h0, cyc_ack}, 8'h01);
		cyc_req = 1'b0;
		prev_lock = lk;
	endtask
	task automatic pulses(input int k);
		repeat (k) begin
			@(negedge ref_clk);
			instr_end = 1'b1;
			@(negedge ref_clk);
			instr_end = 1'b0;
			repeat (4) @(negedge ref_clk);
		end
	endtask
	// compare seen outputs with the oldest note
	always @(negedge ref_clk) begin
		if (bus_if.status_n === 1'b0) begin
			st_seen = {bus_if.m_io, bus_if.code_or_int_ack, bus_if.lock_n, bus_if.cop_operand_ack_n};
			stat_cnt++;
		end
		if (cop_op_done === 1'b1) done_cnt++;
		if (cyc_ack === 1'b1) begin
			if (cyc_q.size() == 0) check("cyc_ack", 8'h01, 8'h00);
			else check("cycle pins", {4'h0, st_seen}, {4'h0, cyc_q.pop_front()});
		end
		if (irq_take === 1'b1) begin
			if (vec_q.size() == 0) check("irq_take", 8'h01, 8'h00);
			else check("irq_vector", irq_vector, vec_q.pop_front());
		end
	end
	// watchdog
	initial begin
		#(40 * 20000);
		mismatches++;
		give_verdict();
	end
	// main sequence
	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		repeat (2) @(negedge ref_clk);
		// every cycle type, acknowledge pair completed so the host pairing stays aligned,
		// random qualifiers, last one unlocked
		for (int i = 0; i < 11; i++) begin
			lfsr_q = lfsr(lfsr_q);
			run_cycle(clb_cyc_t'(i < 7 ? i : (i == 7 ? int'(CYC_IACK) : lfsr_q % 4)),
				i == 10 ? 4'h0 : {lfsr_q[5:3], 1'b0});
		end
		// bus handed to another master, core cycle waits
		mst_req = 1'b1;
		for (n = 0; n < 100 && mst_grant !== 1'b1; n++) @(negedge ref_clk);
		check("bus_hold_ack", {7'h0, bus_if.bus_hold_ack}, 8'h01);
		check("mst_grant", {7'h0, mst_grant}, 8'h01);
		s0 = stat_cnt;
		fork
			run_cycle(CYC_MEM_WR, 4'h0);
			begin
				repeat (20) @(negedge ref_clk);
				check("status in hold", 8'(stat_cnt - s0), 8'h00);
				mst_req = 1'b0;
			end
		join
		check("bus_hold_ack", {7'h0, bus_if.bus_hold_ack}, 8'h00);
		// coprocessor busy, error, operand transfer
		exec_wait = 1'b1;
		cop_busy = 1'b1;
		repeat (6) @(negedge ref_clk);
		check("stall", {7'h0, stall}, 8'h01);
		check("pe_fault", {7'h0, pe_fault}, 8'h00);
		cop_busy = 1'b0;
		cop_error = 1'b1;
		repeat (6) @(negedge ref_clk);
		check("stall", {7'h0, stall}, 8'h00);
		check("pe_fault", {7'h0, pe_fault}, 8'h01);
		exec_wait = 1'b0;
		cop_error = 1'b0;
		cop_opreq = 1'b1;
		@(negedge ref_clk);
		cop_opreq = 1'b0;
		repeat (6) @(negedge ref_clk);
		check("pe_pending", {7'h0, pe_pending}, 8'h01);
		run_cycle(CYC_MEM_RD, 4'h1);
		repeat (6) @(negedge ref_clk);
		check("pe_pending", {7'h0, pe_pending}, 8'h00);
		check("op done", 8'(done_cnt), 8'h01);
		// maskable irq held off by the flag, then taken
		lfsr_q = lfsr(lfsr_q);
		irq_vec_in = lfsr_q[7:0];
		irq_in = 1'b1;
		@(negedge ref_clk);
		irq_in = 1'b0;
		s0 = stat_cnt;
		pulses(6);
		check("iack cycles", 8'(stat_cnt - s0), 8'h00);
		vec_q.push_back(irq_vec_in);
		if_flag = 1'b1;
		pulses(8);
		check("iack cycles", 8'(stat_cnt - s0), 8'h02);
		check("irq pending", 8'(vec_q.size()), 8'h00);
		// nmi with the flag clear
		if_flag = 1'b0;
		s0 = stat_cnt;
		vec_q.push_back(NMI_VECTOR);
		nmi_in = 1'b1;
		@(negedge ref_clk);
		nmi_in = 1'b0;
		repeat (12) @(negedge ref_clk);
		pulses(4);
		check("nmi cycles", 8'(stat_cnt - s0), 8'h00);
		check("nmi pending", 8'(vec_q.size()), 8'h00);
		give_verdict();
	end
endmodule // tb_cpu_local_bus_control_signals
